// [hw/srac_regs.svh]
/*
 * constants of the serial register access block: command word fields,
 * register select codes, reset values and bit counts.
 * assumes it is included by its bare name from the package.
 */
`ifndef SRAC_REGS_SVH
`define SRAC_REGS_SVH

// command word field positions (bits below the leading zero bit)
`define CMD_SEL_HI 5
`define CMD_SEL_LO 4
`define CMD_DIR_BIT 3
`define CMD_STREAM_BIT 2
`define CMD_CH_HI 1
`define CMD_CH_LO 0

// register select codes
`define SEL_CMD_STATUS 2'h0
`define SEL_MODE 2'h1
`define SEL_FILTER 2'h2
`define SEL_DATA 2'h3

// reset values
`define MODE_RST 8'h02
`define FILTER_RST 8'h00
`define CHAN_RST 2'h0
`define STATUS_FIXED 4'h2

// stream exit pattern seen in bits six down to one of the sliding window
`define STREAM_EXIT 6'h0E

// bit counts, held as last index of each group
`define CMD_LAST 5'd6
`define BYTE_LAST 5'd7
`define WORD_LAST 5'd15
`define ONES_LAST 6'd31

// toggle slots crossing from link to system domain
`define T_MODE 0
`define T_FILT 1
`define T_CHAN 2
`define T_RST 3
`define T_RDONE 4

`endif

// [hw/srac_pkg.sv]
/*
 * types of the serial register access block: link state enum and the
 * state records of the link and system clock domains.
 * assumes srac_regs.svh is on the include path.
 */
package srac_pkg;
	`include "srac_regs.svh"

	// link-side interface states
	typedef enum logic [2:0] {
		L_IDLE,
		L_CMD,
		L_WR,
		L_RD,
		L_STREAM
	} srac_lstate_t;

	// all state clocked by the rising serial clock edge
	typedef struct packed {
		srac_lstate_t st;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [1:0] sel;
		logic [5:0] ones;
		logic [7:0] win;
		logic [7:0] mode;
		logic [7:0] filt;
		logic [1:0] chan;
		logic [4:0] tog;
		logic pub_s1;
		logic pub_s2;
		logic pub_seen;
		logic nrdy_s1;
		logic nrdy_s2;
		logic [15:0] dat;
		logic err;
	} srac_link_t;

	// all state clocked by the system clock
	typedef struct packed {
		logic [4:0] t1;
		logic [4:0] t2;
		logic [4:0] t3;
		logic [7:0] mode_o;
		logic [7:0] filt_o;
		logic [1:0] chan_o;
		logic restart;
		logic preset;
		logic nrdy;
		logic [15:0] pub_dat;
		logic pub_err;
		logic pub_tog;
	} srac_sys_t;
endpackage

// [hw/srac_top.sv]
/*
 * serial register access front end: command decode, register read and
 * write over the three-wire port, continuous data read and the
 * all-ones resynchronising reset.
 * assumes a host driving sclk, cs_n and din, and a converter core on
 * sys_clk giving results and taking mode, filter and channel settings.
 */
//
// What this block does
// R01: every access starts with a command write
// R02: command fixes direction and target register
// R03: after the access, back to idle
// R04: reset leaves interface idle awaiting command
// R05: 32 ones on input reset whole part
// R06: command shifted most significant bit first
// R07: leading one ignored; zero starts seven-bit load
// R08: host writes command bit six as zero
// R09: bits five:four select target register
// R10: bit three: zero writes, one reads
// R11: command write-only; select zero reads status
// R12: stream bit with data selected: continuous read
// R13: host enters streaming with 001111XX
// R14: 001110XX while ready low leaves streaming
// R15: streaming still watches input and ones
// R16: host keeps input low while streaming
// R17: bits one:zero select conversion input
// R18: channel change restarts filter and conversion
// R19: output on falling edge, released when deselected
// R20: output low on completion, high before update
// R21: input sampled on rising edge while selected
`timescale 1ns/1ps

module srac_top (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	input wire logic conv_done,
	input wire logic [15:0] conv_result,
	input wire logic conv_err,
	input wire logic conv_stale,
	output logic [7:0] mode_reg,
	output logic [7:0] filter_reg,
	output logic [1:0] input_select,
	output logic filter_restart,
	output logic part_reset
);
	import srac_pkg::*;

	srac_link_t l; // link domain state
	srac_link_t next_l; // link domain next state
	srac_sys_t s; // system domain state
	srac_sys_t next_s; // system domain next state
	logic out_bit; // bit to present at next falling edge
	logic [4:0] ev; // toggle edges seen in system domain

	// register value for a read, left aligned in the shifter
	function automatic logic [15:0] read_word(input srac_link_t st, input logic [1:0] sel);
		logic [15:0] w;
		w = 16'h0000;
		case (sel)
			`SEL_CMD_STATUS: w = {st.nrdy_s2, st.err, `STATUS_FIXED, st.chan, 8'h00}; // [R11]
			`SEL_MODE: w = {st.mode, 8'h00};
			`SEL_FILTER: w = {st.filt, 8'h00};
			default: w = st.dat;
		endcase
		return w;
	endfunction

	// link next-state logic, evaluated per rising serial clock edge
	always_comb begin
		logic [6:0] cmd;
		cmd = {l.sh[5:0], din};
		next_l = l;
		// two-flop catch of the ready level from the system domain
		next_l.nrdy_s1 = s.nrdy;
		next_l.nrdy_s2 = l.nrdy_s1;
		// toggle handshake bringing a fresh result word across
		next_l.pub_s1 = s.pub_tog;
		next_l.pub_s2 = l.pub_s1;
		if (l.pub_s2 != l.pub_seen) begin
			next_l.pub_seen = l.pub_s2;
			next_l.dat = s.pub_dat;
			next_l.err = s.pub_err;
		end
		if (!cs_n) begin // [R21]
			// count consecutive ones in every state
			next_l.ones = din ? l.ones + 6'd1 : 6'd0; // [R15]
			if (din && l.ones == `ONES_LAST) begin
				// resynchronise: whole part back to defaults
				next_l.ones = 6'd0; // [R05]
				next_l.tog[`T_RST] = ~l.tog[`T_RST];
				next_l.st = L_IDLE;
				next_l.mode = `MODE_RST;
				next_l.filt = `FILTER_RST;
				next_l.chan = `CHAN_RST;
				next_l.cnt = 5'd0;
			end else begin
				case (l.st)
					L_IDLE: begin
						// only a command may start here [R01]
						if (!din) begin // [R07]
							next_l.st = L_CMD;
							next_l.cnt = 5'd0;
						end
					end
					L_CMD: begin
						// shift command, first bit highest [R06]
						next_l.sh = {l.sh[14:0], din};
						next_l.cnt = l.cnt + 5'd1;
						if (l.cnt == `CMD_LAST) begin
							next_l.sel = cmd[`CMD_SEL_HI:`CMD_SEL_LO]; // [R09]
							next_l.cnt = 5'd0;
							next_l.chan = cmd[`CMD_CH_HI:`CMD_CH_LO]; // [R17]
							if (cmd[`CMD_CH_HI:`CMD_CH_LO] != l.chan) begin
								// channel moved: core restarts its filter
								next_l.tog[`T_CHAN] = ~l.tog[`T_CHAN]; // [R18]
							end
							if (cmd[`CMD_DIR_BIT]) begin // [R10]
								next_l.sh = read_word(l, cmd[`CMD_SEL_HI:`CMD_SEL_LO]);
								if (cmd[`CMD_SEL_HI:`CMD_SEL_LO] == `SEL_DATA &&
									cmd[`CMD_STREAM_BIT]) begin
									next_l.st = L_STREAM; // [R12]
									next_l.win = 8'h00;
								end else begin
									next_l.st = L_RD; // [R02]
								end
							end else if (cmd[`CMD_SEL_HI:`CMD_SEL_LO] == `SEL_CMD_STATUS) begin
								// a write to the command word is the command itself
								next_l.st = L_IDLE; // [R11]
							end else begin
								next_l.st = L_WR; // [R02]
							end
						end
					end
					L_WR: begin
						// collect one byte for the selected register
						next_l.sh = {l.sh[14:0], din};
						next_l.cnt = l.cnt + 5'd1;
						if (l.cnt == `BYTE_LAST) begin
							next_l.st = L_IDLE; // [R03]
							case (l.sel)
								`SEL_MODE: begin
									next_l.mode = {l.sh[6:0], din};
									next_l.tog[`T_MODE] = ~l.tog[`T_MODE];
								end
								`SEL_FILTER: begin
									next_l.filt = {l.sh[6:0], din};
									next_l.tog[`T_FILT] = ~l.tog[`T_FILT];
								end
								default: begin
									// data register is not writable
									next_l.st = L_IDLE;
								end
							endcase
						end
					end
					L_RD: begin
						// shift the selected register out
						next_l.sh = {l.sh[14:0], 1'b0};
						next_l.cnt = l.cnt + 5'd1;
						if (l.cnt == ((l.sel == `SEL_DATA) ? `WORD_LAST : `BYTE_LAST)) begin
							next_l.st = L_IDLE; // [R03]
							if (l.sel == `SEL_DATA) begin
								next_l.tog[`T_RDONE] = ~l.tog[`T_RDONE];
							end
						end
					end
					L_STREAM: begin
						// data word goes out group after group
						next_l.sh = {l.sh[14:0], 1'b0}; // [R12]
						next_l.cnt = l.cnt + 5'd1;
						if (l.cnt == `WORD_LAST) begin
							next_l.cnt = 5'd0;
							next_l.sh = l.dat;
							next_l.tog[`T_RDONE] = ~l.tog[`T_RDONE];
						end
						// input still watched for the exit command
						next_l.win = {l.win[6:0], din}; // [R15]
						if (l.win[6:1] == `STREAM_EXIT && !l.nrdy_s2) begin
							next_l.st = L_IDLE; // [R14]
							next_l.cnt = 5'd0;
						end
					end
					default: begin
						next_l.st = L_IDLE;
					end
				endcase
			end
		end
	end

	// link registers on the rising serial clock edge
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			l <= '{st: L_IDLE, cnt: 5'd0, sh: 16'h0000, sel: 2'h0, ones: 6'd0,
				win: 8'h00, mode: `MODE_RST, filt: `FILTER_RST, chan: `CHAN_RST,
				tog: 5'h00, pub_s1: 1'b0, pub_s2: 1'b0, pub_seen: 1'b0,
				nrdy_s1: 1'b1, nrdy_s2: 1'b1, dat: 16'h0000, err: 1'b0}; // [R04]
		end else begin
			l <= next_l;
		end
	end

	// data while shifting, otherwise the ready level
	always_comb begin
		if (l.st == L_RD || l.st == L_STREAM) begin
			out_bit = l.sh[15];
		end else begin
			out_bit = l.nrdy_s2; // [R20]
		end
	end

	// output bit changes on the falling serial clock edge
	always_ff @(negedge sclk or negedge rstn) begin
		if (!rstn) begin
			dout <= 1'b1;
		end else begin
			dout <= out_bit; // [R19]
		end
	end

	// pin driven only while selected, released at once on deselect
	always_ff @(negedge sclk or posedge cs_n or negedge rstn) begin
		if (!rstn) begin
			dout_oe <= 1'b0;
		end else if (cs_n) begin
			dout_oe <= 1'b0; // [R19]
		end else begin
			dout_oe <= 1'b1;
		end
	end

	// toggle edges after the two catching flops
	assign ev = s.t2 ^ s.t3;

	// system next-state logic
	always_comb begin
		next_s = s;
		next_s.t1 = l.tog;
		next_s.t2 = s.t1;
		next_s.t3 = s.t2;
		next_s.restart = 1'b0;
		next_s.preset = 1'b0;
		// link words are held stable until the next toggle
		if (ev[`T_MODE]) begin
			next_s.mode_o = l.mode;
			next_s.restart = 1'b1;
		end
		if (ev[`T_FILT]) begin
			next_s.filt_o = l.filt;
		end
		if (ev[`T_CHAN]) begin
			next_s.chan_o = l.chan; // [R17]
			next_s.restart = 1'b1; // [R18]
		end
		// not-ready raised after a data read or before an update
		if (ev[`T_RDONE] || conv_stale) begin
			next_s.nrdy = 1'b1; // [R20]
		end
		// new result lowers not-ready; it wins over a read-done or stale raise
		if (conv_done) begin
			next_s.nrdy = 1'b0; // [R20]
			next_s.pub_dat = conv_result;
			next_s.pub_err = conv_err;
			next_s.pub_tog = ~s.pub_tog;
		end
		// all-ones reset takes the whole part back to defaults
		if (ev[`T_RST]) begin
			next_s.preset = 1'b1; // [R05]
			next_s.mode_o = `MODE_RST;
			next_s.filt_o = `FILTER_RST;
			next_s.chan_o = `CHAN_RST;
			next_s.nrdy = 1'b1;
			next_s.pub_err = 1'b0;
			next_s.pub_dat = 16'h0000;
			next_s.pub_tog = ~s.pub_tog;
		end
	end

	// system registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '{t1: 5'h00, t2: 5'h00, t3: 5'h00, mode_o: `MODE_RST,
				filt_o: `FILTER_RST, chan_o: `CHAN_RST, restart: 1'b0, preset: 1'b0,
				nrdy: 1'b1, pub_dat: 16'h0000, pub_err: 1'b0, pub_tog: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from system flops
	assign mode_reg = s.mode_o;
	assign filter_reg = s.filt_o;
	assign input_select = s.chan_o;
	assign filter_restart = s.restart;
	assign part_reset = s.preset;
endmodule

// [testbench/srac_top_asserts.sv]
/* port checks of the serial register access block.
   assumes binding onto srac_top, all checks on sys_clk. */
`timescale 1ns/1ps
module srac_top_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic dout_oe,
	input wire logic [7:0] mode_reg,
	input wire logic [7:0] filter_reg,
	input wire logic [1:0] input_select,
	input wire logic filter_restart,
	input wire logic part_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_oe_release: assert property (cs_n |-> !dout_oe)
		else $error("output driven while deselected");
	chk_restart_pulse: assert property (filter_restart |=> !filter_restart)
		else $error("filter restart longer than one cycle");
	chk_reset_pulse: assert property (part_reset |=> !part_reset)
		else $error("part reset longer than one cycle");
	chk_chan_restart: assert property (($changed(input_select) && input_select != 2'h0)
		|-> ##[0:2] filter_restart)
		else $error("channel change without filter restart");
	chk_mode_restart: assert property (($changed(mode_reg) && mode_reg != 8'h02)
		|-> ##[0:2] filter_restart)
		else $error("mode write without filter restart");
	chk_reset_vals: assert property ($rose(rstn)
		|-> mode_reg == 8'h02 && filter_reg == 8'h00 && input_select == 2'h0)
		else $error("wrong settings after reset");
	chk_part_mode: assert property (part_reset |-> ##[0:4] mode_reg == 8'h02)
		else $error("mode not restored by part reset");
	chk_part_chan: assert property (part_reset
		|-> ##[0:4] (input_select == 2'h0 && filter_reg == 8'h00))
		else $error("channel or filter not restored by part reset");
	cover property (part_reset);
	cover property ($changed(input_select));
	cover property ($changed(mode_reg));
endmodule
bind srac_top srac_top_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n),
	.dout_oe(dout_oe), .mode_reg(mode_reg), .filter_reg(filter_reg),
	.input_select(input_select), .filter_restart(filter_restart), .part_reset(part_reset));

// [testbench/srac_host.sv]
/* host model: drives the three-wire port with a 15 ns serial clock.
   assumes the clock stands high between frames. */
`timescale 1ns/1ps
module srac_host (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b1;
	end
	// shift n bits out msb first, catch dout at each rising edge
	task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] r);
		r = '0;
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#7.5 sclk = 1'b0;
			din = v[i];
			#7.5 r = {r[30:0], dout};
			sclk = 1'b1;
		end
	endtask
	// end of frame, input line inverted
	task automatic rel();
		#7.5 cs_n = 1'b1;
		din = ~din;
	endtask
endmodule

// [testbench/tb_serial_register_access_control.sv]
/* testbench of the serial register access block.
   assumes srac_top, srac_host and the checker are compiled before it. */
`timescale 1ns/1ps
module tb_serial_register_access_control;
	import srac_pkg::*;
	logic sys_clk, rstn, sclk, cs_n, din, dout, dout_oe, conv_done, conv_err, conv_stale;
	logic [15:0] conv_result;
	logic [7:0] mode_reg, filter_reg;
	logic [1:0] input_select;
	logic filter_restart, part_reset;
	logic [31:0] r;
	int mismatches, n_compared, n_restart, n_reset;
	always #50 sys_clk = ~sys_clk;
	srac_top dut (.sys_clk(sys_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .conv_done(conv_done), .conv_result(conv_result),
		.conv_err(conv_err), .conv_stale(conv_stale), .mode_reg(mode_reg),
		.filter_reg(filter_reg), .input_select(input_select),
		.filter_restart(filter_restart), .part_reset(part_reset));
	srac_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	// count restart and reset pulses
	always @(posedge sys_clk) begin
		if (filter_restart === 1'b1) n_restart++;
		if (part_reset === 1'b1) n_reset++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// command, then n data bits, then deselect and let settings cross
	task automatic op(input logic [7:0] cmd, input int n, input logic [15:0] d);
		host.xfer(8, {24'h0, cmd}, r);
		host.xfer(n, {16'h0, d}, r);
		host.rel();
		repeat (6) @(negedge sys_clk);
	endtask
	// one finished conversion from the core
	task automatic done(input logic [15:0] v);
		@(negedge sys_clk);
		conv_result = v;
		conv_done = 1'b1;
		@(negedge sys_clk);
		conv_done = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic end_sim();
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		conv_done = 1'b0;
		conv_err = 1'b0;
		conv_stale = 1'b0;
		conv_result = 16'h0000;
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		@(negedge sys_clk);
		chk(mode_reg, 8'h02);
		chk(dout_oe, 1'b0);
		host.xfer(2, 32'h3, r);
		op(8'h10, 8, 16'h12);
		chk(mode_reg, 8'h12);
		chk(n_restart, 1);
		op(8'h20, 8, 16'h5A);
		chk(filter_reg, 8'h5A);
		op(8'h18, 8, 16'h0);
		chk(r, 32'h12);
		op(8'h28, 8, 16'h0);
		chk(r, 32'h5A);
		for (int c = 0; c < 4; c++) begin
			op({6'h00, c[1:0]}, 0, 16'h0);
			chk(input_select, c[1:0]);
		end
		chk(n_restart, 4);
		op(8'h08, 8, 16'h0);
		chk(r, 32'h8B);
		done(16'hA55A);
		op(8'h08, 8, 16'h0);
		chk(r, 32'h08);
		op(8'h38, 16, 16'h0);
		chk(r, 32'hA55A);
		op(8'h08, 8, 16'h0);
		chk(r, 32'h88);
		done(16'h1234);
		op(8'h3C, 16, 16'h0);
		chk(r, 32'h1234);
		done(16'h0F0F);
		// group already loaded at the last boundary, fresh word follows
		host.xfer(16, 32'h0, r);
		chk(r, 32'h1234);
		repeat (6) @(negedge sys_clk);
		host.xfer(16, 32'h0, r);
		chk(r, 32'h0F0F);
		// let the read-done raise of not-ready settle before the new result
		repeat (6) @(negedge sys_clk);
		done(16'h0F0F);
		op(8'h38, 0, 16'h0);
		op(8'h18, 8, 16'h0);
		chk(r, 32'h12);
		host.xfer(32, 32'hFFFFFFFF, r);
		host.rel();
		repeat (8) @(negedge sys_clk);
		chk(n_reset, 1);
		chk(mode_reg, 8'h02);
		op(8'h28, 8, 16'h0);
		chk(r, 32'h00);
		end_sim();
	end
endmodule
